// ---- include/irq_state_defs.vh ----
`ifndef IRQ_STATE_DEFS_VH
`define IRQ_STATE_DEFS_VH

`define NIRQ            8
`define NIRQ_W          3
`define PRIO_W          4
`define PRIO_NONE       4'hf
`define IRQ_ID_W        9
`define IRQ_ID_MAX      9'h0ef
`define ADDR_W          12
`define ACTIVE_OFS      12'h000
`define PRIO_OFS        12'h100
`define PRIO_OFS_END    12'h104
`define TRIG_OFS        12'he00
`define ENABLE_OFS      12'h010
`define PEND_OFS        12'h014
`define PEND_CLR_OFS    12'h018
`define LEVEL_OFS       12'h01c
`define CTRL_OFS        12'h020
`define TAKE_OFS        12'h024
`define CTRL_UNPRIV_BIT 0
`define TAKE_RET_BIT    8
`define TAKE_VALID_BIT  31
`define BEST_OFS        12'h028
`define WORD_LSB        2
`define PRIO_BYTE_W     8
`define PRIO_LO_W       4
`define PRIO_LANES      4
`define PRIO_WORD_BIT   2
`define IRQ_ID_LIMIT    9'h008

`endif

// ---- hw/irq_state_priority_trigger.v ----
// Function
// - active flag reads 1 when interrupt is active or active-and-pending
// - one 8-bit priority field per interrupt, four per word, byte access
// - lower priority value wins arbitration
// - only priority bits 7:4 stored; bits 3:0 read zero, writes dropped
// - interrupt N priority in word N/4, byte N mod 4; only the word at 0x100 is decoded, so interrupts 4..7 keep priority 0
// - trigger write pends interrupt named in 9-bit id, valid 0..7
// - unprivileged trigger writes honoured only when permission bit set
// - request lines sampled every clock, pulses latched as pending
// - level: line high while not active makes interrupt pending
// - rising edge on line makes interrupt pending
// - service entry clears pending and sets active
// - level: on return, pending if line high else inactive
// - pulse during service: pending and active, pending after return
// - pulse with no new pulse: inactive after return
// - clear-pending on level with line high leaves state unchanged
// - clear-pending on pulse: pending to inactive, active-pending to active
// - pending capture works while disabled
// - only enabled pending interrupts are offered, by priority
// - clear-pending never alters active state
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/10ps
`include "irq_state_defs.vh"
module irq_state_priority_trigger (
    input  wire                  mclk,
    input  wire                  nrst,
    input  wire [`ADDR_W-1:0]    address,
    input  wire                  read,
    input  wire                  write,
    input  wire [31:0]           writedata,
    input  wire [3:0]            byteenable,
    input  wire                  privileged,
    output reg  [31:0]           readdata,
    output reg                   waitrequest,
    input  wire [`NIRQ-1:0]      irq_req,
    output reg                   irq_avail,
    output reg  [`NIRQ_W-1:0]    irq_best,
    output reg  [`NIRQ-1:0]      active_out
);

    reg               rst_s1_r;
    reg               rst_s2_r;
    wire              rst_n = rst_s2_r;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // three-stage sampling of asynchronous request pins
    reg  [`NIRQ-1:0]  req_s1_r;
    reg  [`NIRQ-1:0]  req_s2_r;
    reg  [`NIRQ-1:0]  req_s3_r;
    reg  [`NIRQ-1:0]  req_lvl_r;
    wire [`NIRQ-1:0]  req_agree = ~(req_s2_r ^ req_s3_r);
    wire [`NIRQ-1:0]  req_lvl_nxt = (req_agree & req_s2_r) | (~req_agree & req_lvl_r);
    wire [`NIRQ-1:0]  req_rise = req_lvl_nxt & ~req_lvl_r;

    reg  [`NIRQ-1:0]      pend_r;
    reg  [`NIRQ-1:0]      act_r;
    reg  [`NIRQ-1:0]      en_r;
    reg  [`NIRQ-1:0]      level_r;
    reg                   unpriv_r;
    reg  [`PRIO_W-1:0]    prio_r [0:`NIRQ-1];

    reg  [`NIRQ-1:0]      pend_nxt;
    reg  [`NIRQ-1:0]      act_nxt;
    reg  [`NIRQ-1:0]      take_set;
    reg  [`NIRQ-1:0]      ret_set;
    reg  [`NIRQ-1:0]      clr_set;
    reg  [`NIRQ-1:0]      sw_set;
    reg  [31:0]           rdata_nxt;
    reg                   best_ok;
    reg  [`NIRQ_W-1:0]    best_idx;
    reg  [`PRIO_W-1:0]    best_prio;
    integer               i;
    integer               ia;
    integer               ir;
    integer               ip;

    function [`NIRQ-1:0] onehot;
        input [`NIRQ_W-1:0] n;
        begin
            onehot = {{(`NIRQ-1){1'b0}}, 1'b1} << n;
        end
    endfunction

    function is_reg;
        input [`ADDR_W-1:0] a;
        input [`ADDR_W-1:0] ofs;
        begin
            is_reg = (a == ofs);
        end
    endfunction

    // stored nibble widened to a byte lane, low bits fixed at zero
    function [`PRIO_BYTE_W-1:0] prio_lane;
        input [`PRIO_W-1:0] p;
        begin
            prio_lane = {p, {(`PRIO_BYTE_W-`PRIO_W){1'b0}}};
        end
    endfunction

    function [`NIRQ_W-1:0] prio_idx;
        input       hi_word;
        input [1:0] lane;
        begin
            prio_idx = {hi_word, lane};
        end
    endfunction

    // waitrequest drops in the cycle after the request; a write lands at the
    // edge where the master sees it low, so both sides agree on one edge
    wire               acc      = (read | write) & waitrequest;
    wire               wr_acc   = write & ~waitrequest;
    wire [`ADDR_W-1:0] word_a   = {address[`ADDR_W-1:`WORD_LSB], {`WORD_LSB{1'b0}}};
    wire               prio_hit = (word_a >= `PRIO_OFS) && (word_a < `PRIO_OFS_END);

    always @* begin
        take_set = {`NIRQ{1'b0}};
        ret_set  = {`NIRQ{1'b0}};
        if (wr_acc && is_reg(word_a, `TAKE_OFS)) begin
            if (writedata[`TAKE_RET_BIT])
                ret_set = onehot(writedata[`NIRQ_W-1:0]);
            else
                take_set = onehot(writedata[`NIRQ_W-1:0]);
        end
    end

    always @* begin
        clr_set = {`NIRQ{1'b0}};
        if (wr_acc && is_reg(word_a, `PEND_CLR_OFS))
            clr_set = writedata[`NIRQ-1:0];
    end

    // ids past the implemented range are dropped without a trace
    wire               trig_priv_ok = privileged | unpriv_r;
    wire               trig_id_ok   = (writedata[`IRQ_ID_W-1:0] < `IRQ_ID_LIMIT);
    wire               trig_hit     = wr_acc & is_reg(word_a, `TRIG_OFS) & trig_priv_ok & trig_id_ok;
    wire               set_hit      = wr_acc & is_reg(word_a, `PEND_OFS);

    always @* begin
        sw_set = {`NIRQ{1'b0}};
        if (trig_hit)
            sw_set = onehot(writedata[`NIRQ_W-1:0]);
        if (set_hit)
            sw_set = sw_set | writedata[`NIRQ-1:0];
    end

    always @* begin
        for (i = 0; i < `NIRQ; i = i + 1) begin
            pend_nxt[i] = pend_r[i];
            act_nxt[i]  = act_r[i];
            if (take_set[i]) begin
                pend_nxt[i] = 1'b0;
                act_nxt[i]  = 1'b1;
            end
            if (ret_set[i]) begin
                act_nxt[i] = 1'b0;
                if (level_r[i])
                    pend_nxt[i] = req_lvl_r[i];
                // pulse keeps its pending bit
            end
            if (clr_set[i]) begin
                if (!(level_r[i] && req_lvl_r[i]))
                    pend_nxt[i] = 1'b0;
            end
            // hardware sets win over clears; enable not consulted
            if (level_r[i] && req_lvl_nxt[i] && !act_nxt[i])
                pend_nxt[i] = 1'b1;
            if (req_rise[i])
                pend_nxt[i] = 1'b1;
            if (sw_set[i])
                pend_nxt[i] = 1'b1;
        end
    end

    // a candidate must be both pending and enabled
    wire [`NIRQ-1:0]   cand = pend_r & en_r;

    function beats;
        input [`PRIO_W-1:0] p;
        input [`PRIO_W-1:0] q;
        begin
            beats = (p <= q);
        end
    endfunction

    // scanning down from the top lets the lowest number claim ties
    always @* begin
        best_ok   = 1'b0;
        best_idx  = {`NIRQ_W{1'b0}};
        best_prio = `PRIO_NONE;
        for (ia = `NIRQ - 1; ia >= 0; ia = ia - 1) begin
            if (cand[ia] && (!best_ok || beats(prio_r[ia], best_prio))) begin
                best_ok   = 1'b1;
                best_idx  = ia[`NIRQ_W-1:0];
                best_prio = prio_r[ia];
            end
        end
    end

    always @* begin
        rdata_nxt = 32'h0000_0000;
        if (prio_hit) begin
            for (ir = 0; ir < `PRIO_LANES; ir = ir + 1)
                rdata_nxt[ir*`PRIO_BYTE_W +: `PRIO_BYTE_W] =
                    prio_lane(prio_r[prio_idx(word_a[`PRIO_WORD_BIT], ir[1:0])]);
        end else begin
            case (word_a)
                `ACTIVE_OFS: rdata_nxt[`NIRQ-1:0] = act_r;
                `ENABLE_OFS: rdata_nxt[`NIRQ-1:0] = en_r;
                `PEND_OFS,
                `PEND_CLR_OFS: rdata_nxt[`NIRQ-1:0] = pend_r;
                `LEVEL_OFS: rdata_nxt[`NIRQ-1:0] = level_r;
                `CTRL_OFS: rdata_nxt[`CTRL_UNPRIV_BIT] = unpriv_r;
                `BEST_OFS: rdata_nxt = {best_ok, 28'h0000000, best_idx};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            req_s1_r  <= {`NIRQ{1'b0}};
            req_s2_r  <= {`NIRQ{1'b0}};
            req_s3_r  <= {`NIRQ{1'b0}};
            req_lvl_r <= {`NIRQ{1'b0}};
        end else begin
            req_s1_r  <= irq_req;
            req_s2_r  <= req_s1_r;
            req_s3_r  <= req_s2_r;
            req_lvl_r <= req_lvl_nxt;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r <= {`NIRQ{1'b0}};
            act_r  <= {`NIRQ{1'b0}};
        end else begin
            pend_r <= pend_nxt;
            act_r  <= act_nxt;
        end
    end

    // outputs registered so the core sees clean levels
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_avail  <= 1'b0;
            irq_best   <= {`NIRQ_W{1'b0}};
            active_out <= {`NIRQ{1'b0}};
        end else begin
            irq_avail  <= best_ok;
            irq_best   <= best_idx;
            active_out <= act_nxt;
        end
    end

    // waitrequest high by default; low for one cycle to end an access
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else begin
            waitrequest <= ~acc;
            if (acc && read)
                readdata <= rdata_nxt;
        end
    end

    // a lane without its byteenable keeps the old field
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (ip = 0; ip < `NIRQ; ip = ip + 1)
                prio_r[ip] <= {`PRIO_W{1'b0}};
        end else if (wr_acc && prio_hit) begin
            for (ip = 0; ip < `PRIO_LANES; ip = ip + 1)
                if (byteenable[ip])
                    prio_r[prio_idx(word_a[`PRIO_WORD_BIT], ip[1:0])] <=
                        writedata[ip*`PRIO_BYTE_W+`PRIO_LO_W +: `PRIO_W];
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            en_r <= {`NIRQ{1'b0}};
        else if (wr_acc && is_reg(word_a, `ENABLE_OFS))
            en_r <= writedata[`NIRQ-1:0];
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            level_r <= {`NIRQ{1'b0}};
        else if (wr_acc && is_reg(word_a, `LEVEL_OFS))
            level_r <= writedata[`NIRQ-1:0];
    end

    // only privileged code may open the trigger to unprivileged writers
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            unpriv_r <= 1'b0;
        else if (wr_acc && is_reg(word_a, `CTRL_OFS) && privileged)
            unpriv_r <= writedata[`CTRL_UNPRIV_BIT];
    end

endmodule

// ---- test/irq_state_props.sv ----
`timescale 1ns/10ps
`include "irq_state_defs.vh"
module irq_state_props (
    input wire logic [11:0] address,
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        read,
    input wire logic        write,
    input wire logic        waitrequest,
    input wire logic [31:0] readdata,
    input wire logic [7:0]  active_out,
    input wire logic        irq_avail
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire rd_done = read && !waitrequest;
    wire take = write && !waitrequest && address == `TAKE_OFS;
    a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer");
    a_wait_pulse: assert property (!waitrequest |=> waitrequest) else $error("wait low too long");
    a_idle_wait: assert property (!read && !write |=> waitrequest) else $error("answer without request");
    a_unmapped_zero: assert property (rd_done && address == 12'h0fc |-> readdata == 32'h0) else $error("unmapped");
    a_trig_zero: assert property (rd_done && address == `TRIG_OFS |-> readdata == 32'h0) else $error("trig read");
    a_prio_low: assert property (rd_done && address[11:3] == 9'h020 |-> (readdata & 32'h0f0f0f0f) == 32'h0)
        else $error("prio low bits");
    a_act_read: assert property (rd_done && address == `ACTIVE_OFS |-> readdata[31:8] == 24'h0 &&
        (readdata[7:0] == active_out || readdata[7:0] == $past(active_out))) else $error("active read");
    // active moves only by service entry or return, never by clear-pending
    a_act_cause: assert property (active_out != $past(active_out) |-> $past(take) || $past(take, 2))
        else $error("active changed alone");
    c_take: cover property (take);
    c_avail: cover property ($rose(irq_avail));
    c_act: cover property (active_out != 8'h00);
endmodule

// ---- test/irq_source.sv ----
`timescale 1ns/10ps
module irq_source (
    input wire logic       mclk,
    input wire logic [7:0] lvl,
    input wire logic [7:0] pls,
    output logic [7:0]     irq_req
);
    logic [7:0] a_r;
    logic [7:0] b_r;
    initial irq_req = 8'h00;
    // stretched to three clocks so the synchroniser sees two equal samples
    always @(posedge mclk) begin
        a_r <= pls;
        b_r <= a_r;
        irq_req <= lvl | pls | a_r | b_r;
    end
endmodule

// ---- test/irq_state_priority_trigger_bench.sv ----
`timescale 1ns/10ps
`include "irq_state_defs.vh"
module irq_state_priority_trigger_bench;
    logic mclk, nrst, read, write, privileged, irq_avail, waitrequest;
    logic [11:0] address;
    logic [31:0] writedata, readdata, r;
    logic [3:0]  byteenable;
    logic [7:0]  irq_req, lvl, pls, active_out;
    logic [2:0]  irq_best;
    logic [31:0] expq[$];
    int mismatches, checked;
    irq_state_priority_trigger dut (.mclk(mclk), .nrst(nrst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .privileged(privileged), .readdata(readdata),
        .waitrequest(waitrequest), .irq_req(irq_req), .irq_avail(irq_avail), .irq_best(irq_best),
        .active_out(active_out));
    irq_source src (.mclk(mclk), .lvl(lvl), .pls(pls), .irq_req(irq_req));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task print_verdict;
        if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task cmp(input logic [11:0] a, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] reg %h exp %h got %h", a, e, g);
        end
    endtask
    task cmp_irq(input logic ea, input logic [2:0] eb);
        checked++;
        if ({irq_avail, irq_best} !== {ea, eb}) begin
            mismatches++;
            $display("[FAIL] irq_best exp %h got %h", {ea, eb}, {irq_avail, irq_best});
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be, input logic pv);
        address <= a;
        writedata <= d;
        byteenable <= be;
        privileged <= pv;
        read <= !w;
        write <= w;
        @(posedge mclk);
        while (waitrequest !== 1'b0) @(posedge mclk);
        read <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf, 1'b1);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0, 4'hf, 1'b1);
    endtask
    task pulse0;
        pls <= 8'h01;
        @(posedge mclk);
        pls <= 8'h00;
        repeat (8) @(posedge mclk);
    endtask
    always @(posedge mclk) begin
        if (read === 1'b1 && waitrequest === 1'b0) cmp(address, expq.pop_front(), readdata);
    end
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        print_verdict;
    end
    initial begin
        {nrst, read, write, privileged, address, writedata, byteenable, lvl, pls} = '0;
        r = xs(32'h8556898a);
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(`ACTIVE_OFS, 32'h0);
        rd(`TRIG_OFS, 32'h0);
        rd(12'h0fc, 32'h0);
        wr(`PRIO_OFS, r);
        rd(`PRIO_OFS, r & 32'hf0f0f0f0);
        bus(1'b1, `PRIO_OFS, 32'h00005a00, 4'h2, 1'b1);
        rd(`PRIO_OFS, (r & 32'hf0f000f0) | 32'h5000);
        wr(`PRIO_OFS, 32'h20303040);
        wr(`PRIO_OFS_END, 32'hf0f0f0f0);
        bus(1'b1, `TRIG_OFS, 32'h7, 4'hf, 1'b0);
        wr(`TRIG_OFS, 32'hc8);
        wr(`TRIG_OFS, 32'h1);
        wr(`TRIG_OFS, 32'h2);
        rd(`PEND_OFS, 32'h6);
        rd(`BEST_OFS, 32'h0);
        wr(`ENABLE_OFS, 32'hff);
        rd(`BEST_OFS, 32'h80000001);
        wr(`TRIG_OFS, 32'h3);
        rd(`BEST_OFS, 32'h80000003);
        cmp_irq(1'b1, 3'h3);
        wr(`CTRL_OFS, 32'h1);
        bus(1'b1, `TRIG_OFS, 32'h7, 4'hf, 1'b0);
        rd(`PEND_OFS, 32'h8e);
        wr(`PEND_CLR_OFS, 32'hff);
        rd(`PEND_OFS, 32'h0);
        cmp_irq(1'b0, 3'h0);
        wr(`LEVEL_OFS, 32'h2);
        lvl <= 8'h02;
        repeat (8) @(posedge mclk);
        rd(`PEND_OFS, 32'h2);
        wr(`TAKE_OFS, 32'h1);
        rd(`ACTIVE_OFS, 32'h2);
        rd(`PEND_OFS, 32'h0);
        wr(`TAKE_OFS, 32'h101);
        rd(`PEND_OFS, 32'h2);
        wr(`PEND_CLR_OFS, 32'h2);
        rd(`PEND_OFS, 32'h2);
        lvl <= 8'h00;
        repeat (8) @(posedge mclk);
        wr(`PEND_CLR_OFS, 32'h2);
        rd(`PEND_OFS, 32'h0);
        pulse0;
        rd(`PEND_OFS, 32'h1);
        wr(`TAKE_OFS, 32'h0);
        pulse0;
        rd(`PEND_OFS, 32'h1);
        wr(`TAKE_OFS, 32'h100);
        rd(`ACTIVE_OFS, 32'h0);
        rd(`PEND_OFS, 32'h1);
        wr(`TAKE_OFS, 32'h0);
        pulse0;
        wr(`PEND_CLR_OFS, 32'h1);
        rd(`PEND_OFS, 32'h0);
        rd(`ACTIVE_OFS, 32'h1);
        wr(`TAKE_OFS, 32'h100);
        rd(`ACTIVE_OFS, 32'h0);
        print_verdict;
    end
endmodule
bind irq_state_priority_trigger irq_state_props chk (.address(address), .mclk(mclk), .nrst(nrst), .read(read),
    .write(write), .waitrequest(waitrequest), .readdata(readdata), .active_out(active_out), .irq_avail(irq_avail));
